//--- rtl/i2cfd_pkg.sv
// Constants and types shared by the flush, DMA enable and filter block
package i2cfd_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  // Cycles spent passing the flush request out and its acknowledge back
  localparam logic [2:0]  FLUSH_REQ_CYC = 3'h2;
  localparam logic [2:0]  FLUSH_ACK_CYC = 3'h2;
  // Filter select codes and removed spike widths in clock cycles
  localparam logic [1:0]  FLT_OFF   = 2'h0;
  localparam logic [1:0]  FLT_ONE   = 2'h1;
  localparam logic [1:0]  FLT_TWO   = 2'h2;
  localparam logic [1:0]  FLT_FOUR  = 2'h3;
  localparam logic [2:0]  SPIKE_ONE  = 3'h1;
  localparam logic [2:0]  SPIKE_TWO  = 3'h2;
  localparam logic [2:0]  SPIKE_FOUR = 3'h4;
  // Values after reset
  localparam logic [1:0]  RST_FLT_SEL = 2'h0;
  localparam logic        RST_DMA_EN  = 1'b0;
  localparam logic [1:0]  RST_LINES   = 2'h3;

  typedef enum logic [1:0] {FL_IDLE, FL_REQ, FL_ACK} i2cfd_flush_t;
endpackage

//--- rtl/i2cfd_fifo.sv
// Flop-based FIFO with valid/ready on both sides and a synchronous flush
`timescale 1ns/1ns
module i2cfd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  // Pointers wrap naturally, so DEPTH must be a power of two
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 cnt;
  } i2cfd_fifo_state_t;

  i2cfd_fifo_state_t st_ff;
  i2cfd_fifo_state_t nxt_st;
  logic              push;
  logic              pop;

  assign in_ready  = (st_ff.cnt != FULL_CNT) && !flush;
  assign out_valid = (st_ff.cnt != '0) && !flush;
  assign out_data  = st_ff.mem[st_ff.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (flush) begin
      nxt_st.wptr = '0;
      nxt_st.rptr = '0;
      nxt_st.cnt  = '0;
    end else begin
      if (push) begin
        nxt_st.mem[st_ff.wptr] = in_data;
        nxt_st.wptr = st_ff.wptr + 1'b1;
      end
      if (pop) begin
        nxt_st.rptr = st_ff.rptr + 1'b1;
      end
      if (push && !pop) begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end else if (pop && !push) begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
endmodule // i2cfd_fifo

//--- rtl/i2cfd_ctrl.sv
// Flush sequencers, DMA enables and line spike filters of the I2C node
// Functional notes
// R1: A receive flush request empties the receive FIFO and state, keeping config.
// R2: The flush runs several cycles and the block clears the flush bit itself.
// R3: Software must not read the receive FIFO during a flush and polls the bit.
// R4: Flush bit high means flush running, low means done and cleared by hardware.
// R5: Transmit DMA enable puts the transmit request side in run or idle state.
// R6: DMA end of transfer clears the transmit DMA enable.
// R7: Receive DMA enable puts the receive request side in run or idle state.
// R8: DMA end of transfer clears the receive DMA enable.
// R9: Software never sets both DMA enables at the same time.
// R10: A two-bit select inserts digital spike filters on SDA and SCL.
// R11: Select 0 is no filter, 1, 2 and 3 remove spikes 1, 2 and 4 clocks wide.
// R12: A transmit flush empties the transmit state likewise and self-clears.
// R13: The flush request is passed out and acknowledged back before clearing.
`timescale 1ns/1ns
module i2cfd_ctrl (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic                        rx_flush_set,
  input  wire logic                        tx_flush_set,
  output logic                             rx_flush,
  output logic                             tx_flush,
  input  wire logic                        dma_tx_en_wr,
  input  wire logic                        dma_tx_en_wdata,
  input  wire logic                        dma_rx_en_wr,
  input  wire logic                        dma_rx_en_wdata,
  output logic                             dma_tx_en,
  output logic                             dma_rx_en,
  input  wire logic                        dma_eot,
  output logic                             dma_tx_req,
  output logic                             dma_rx_req,
  input  wire logic                        filter_wr,
  input  wire logic [1:0]                  line_filter_select_wdata,
  output logic      [1:0]                  line_filter_select,
  input  wire logic                        sda_in,
  input  wire logic                        scl_in,
  output logic                             sda_filt,
  output logic                             scl_filt,
  input  wire logic                        rx_byte_valid,
  output logic                             rx_byte_ready,
  input  wire logic [i2cfd_pkg::DATA_W-1:0] rx_byte,
  output logic                             rd_valid,
  input  wire logic                        rd_ready,
  output logic      [i2cfd_pkg::DATA_W-1:0] rd_data,
  input  wire logic                        tx_wr_valid,
  output logic                             tx_wr_ready,
  input  wire logic [i2cfd_pkg::DATA_W-1:0] tx_wr_data,
  output logic                             tx_byte_valid,
  input  wire logic                        tx_byte_ready,
  output logic      [i2cfd_pkg::DATA_W-1:0] tx_byte
);
  import i2cfd_pkg::*;

  typedef struct packed {
    i2cfd_flush_t          rx_fl;
    i2cfd_flush_t          tx_fl;
    logic [2:0]            rx_cnt;
    logic [2:0]            tx_cnt;
    logic                  rx_busy;
    logic                  tx_busy;
    logic                  dma_tx_en;
    logic                  dma_rx_en;
    logic [1:0]            flt_sel;
    logic [1:0]            flt_out;
    logic [1:0][2:0]       flt_cnt;
    logic [DATA_W-1:0]     tx_hold;
    logic                  tx_full;
  } i2cfd_state_t;

  i2cfd_state_t st_ff;
  i2cfd_state_t nxt_st;
  logic         rx_fifo_flush;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic [1:0]   line_in;

  function automatic logic [2:0] spike_width(input logic [1:0] sel);
    case (sel)
      FLT_OFF:  spike_width = 3'h0;
      FLT_ONE:  spike_width = SPIKE_ONE;
      FLT_TWO:  spike_width = SPIKE_TWO;
      FLT_FOUR: spike_width = SPIKE_FOUR;
      default:  spike_width = 3'h0;
    endcase
  endfunction

  assign line_in            = {scl_in, sda_in};
  assign rx_flush           = st_ff.rx_busy; // R4
  assign tx_flush           = st_ff.tx_busy; // R4
  assign dma_tx_en          = st_ff.dma_tx_en;
  assign dma_rx_en          = st_ff.dma_rx_en;
  assign line_filter_select = st_ff.flt_sel;
  assign sda_filt           = st_ff.flt_out[0];
  assign scl_filt           = st_ff.flt_out[1];
  assign rx_fifo_flush      = (st_ff.rx_fl == FL_REQ); // R1
  // Reads are held off during a flush so a stray pop cannot corrupt pointers
  assign rx_byte_ready      = fifo_in_ready && !st_ff.rx_busy;
  assign rd_valid           = fifo_out_valid && !st_ff.rx_busy; // R3
  assign dma_rx_req         = st_ff.dma_rx_en && rd_valid; // R7
  assign tx_wr_ready        = !st_ff.tx_full && !st_ff.tx_busy;
  assign dma_tx_req         = st_ff.dma_tx_en && tx_wr_ready; // R5
  assign tx_byte_valid      = st_ff.tx_full && !st_ff.tx_busy;
  assign tx_byte            = st_ff.tx_hold;

  i2cfd_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .flush     (rx_fifo_flush),
    .in_valid  (rx_byte_valid && !st_ff.rx_busy),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte),
    .out_valid (fifo_out_valid),
    .out_ready (rd_ready && !st_ff.rx_busy),
    .out_data  (rd_data)
  );

  always_comb begin
    nxt_st = st_ff;
    // Receive flush: request phase, acknowledge phase, then self-clear
    case (st_ff.rx_fl)
      FL_IDLE: begin
        if (rx_flush_set) begin
          nxt_st.rx_fl   = FL_REQ; // R1
          nxt_st.rx_busy = 1'b1;
          nxt_st.rx_cnt  = 3'h0;
        end
      end
      FL_REQ: begin
        nxt_st.rx_cnt = st_ff.rx_cnt + 3'h1;
        if (st_ff.rx_cnt == FLUSH_REQ_CYC - 3'h1) begin
          nxt_st.rx_fl  = FL_ACK; // R13
          nxt_st.rx_cnt = 3'h0;
        end
      end
      FL_ACK: begin
        nxt_st.rx_cnt = st_ff.rx_cnt + 3'h1;
        if (st_ff.rx_cnt == FLUSH_ACK_CYC - 3'h1) begin
          // A new request landing on completion restarts the flush
          nxt_st.rx_fl   = rx_flush_set ? FL_REQ : FL_IDLE; // R2
          nxt_st.rx_busy = rx_flush_set;
          nxt_st.rx_cnt  = 3'h0;
        end
      end
      default: nxt_st.rx_fl = FL_IDLE;
    endcase
    // Transmit flush mirrors the receive one and empties the holding stage
    case (st_ff.tx_fl)
      FL_IDLE: begin
        if (tx_flush_set) begin
          nxt_st.tx_fl   = FL_REQ; // R12
          nxt_st.tx_busy = 1'b1;
          nxt_st.tx_cnt  = 3'h0;
        end
      end
      FL_REQ: begin
        nxt_st.tx_full = 1'b0; // R12
        nxt_st.tx_cnt  = st_ff.tx_cnt + 3'h1;
        if (st_ff.tx_cnt == FLUSH_REQ_CYC - 3'h1) begin
          nxt_st.tx_fl  = FL_ACK; // R13
          nxt_st.tx_cnt = 3'h0;
        end
      end
      FL_ACK: begin
        nxt_st.tx_cnt = st_ff.tx_cnt + 3'h1;
        if (st_ff.tx_cnt == FLUSH_ACK_CYC - 3'h1) begin
          nxt_st.tx_fl   = tx_flush_set ? FL_REQ : FL_IDLE; // R12
          nxt_st.tx_busy = tx_flush_set;
          nxt_st.tx_cnt  = 3'h0;
        end
      end
      default: nxt_st.tx_fl = FL_IDLE;
    endcase
    if (st_ff.tx_fl == FL_IDLE && !tx_flush_set) begin
      if (tx_byte_valid && tx_byte_ready) begin
        nxt_st.tx_full = 1'b0;
      end
      if (tx_wr_valid && tx_wr_ready) begin
        nxt_st.tx_hold = tx_wr_data;
        nxt_st.tx_full = 1'b1;
      end
    end
    // End of transfer clears the enables; a write of one in the same cycle wins
    if (dma_eot) begin
      nxt_st.dma_tx_en = 1'b0; // R6
      nxt_st.dma_rx_en = 1'b0; // R8
    end
    if (dma_tx_en_wr && (dma_tx_en_wdata || !dma_eot)) begin
      nxt_st.dma_tx_en = dma_tx_en_wdata; // R5
    end
    if (dma_rx_en_wr && (dma_rx_en_wdata || !dma_eot)) begin
      nxt_st.dma_rx_en = dma_rx_en_wdata; // R7
    end
    if (filter_wr) begin
      nxt_st.flt_sel = line_filter_select_wdata; // R10
    end
    // Output follows only once the input has differed longer than the spike
    for (int i = 0; i < 2; i++) begin
      if (line_in[i] == st_ff.flt_out[i]) begin
        nxt_st.flt_cnt[i] = 3'h0;
      end else if (st_ff.flt_cnt[i] >= spike_width(st_ff.flt_sel)) begin
        nxt_st.flt_out[i] = line_in[i]; // R11
        nxt_st.flt_cnt[i] = 3'h0;
      end else begin
        nxt_st.flt_cnt[i] = st_ff.flt_cnt[i] + 3'h1; // R10
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff           <= '0;
      st_ff.rx_fl     <= FL_IDLE;
      st_ff.tx_fl     <= FL_IDLE;
      st_ff.dma_tx_en <= RST_DMA_EN;
      st_ff.dma_rx_en <= RST_DMA_EN;
      st_ff.flt_sel   <= RST_FLT_SEL;
      st_ff.flt_out   <= RST_LINES;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  a_rx_flush_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && rx_flush_set |=> rx_flush) // R4
    else $error("rx flush bit did not rise");
  // Multi-cycle checks assume clk_en stays high across their span
  // A set in the final acknowledge cycle restarts, so it is excluded there
  a_rx_flush_ends: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && rx_flush_set && !rx_flush ##1 clk_en [*3]
    ##1 (clk_en && !rx_flush_set) |=> !rx_flush) // R2
    else $error("rx flush bit did not self clear");
  a_tx_flush_ends: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && tx_flush_set && !tx_flush ##1 clk_en [*3]
    ##1 (clk_en && !tx_flush_set) |=> !tx_flush) // R12
    else $error("tx flush bit did not self clear");
  a_flush_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
    !clk_en |=> rx_flush == $past(rx_flush)) // R2
    else $error("rx flush bit moved while frozen");
  a_flush_keeps_cfg: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && rx_flush_set && !filter_wr
    |=> line_filter_select == $past(line_filter_select)) // R1
    else $error("flush disturbed filter setting");
  a_rx_push_held: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_flush |-> !rx_byte_ready) // R1
    else $error("rx push accepted during flush");
  a_rx_fifo_empty: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && rx_fifo_flush |=> !fifo_out_valid) // R1
    else $error("rx fifo kept data through flush");
  a_flush_ack_order: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(rx_flush) |-> $past(st_ff.rx_fl) == FL_ACK) // R13
    else $error("rx flush cleared before acknowledge");
  a_tx_ack_order: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(tx_flush) |-> $past(st_ff.tx_fl) == FL_ACK) // R13
    else $error("tx flush cleared before acknowledge");
  a_tx_held_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    tx_flush |-> !tx_wr_ready && !tx_byte_valid && !dma_tx_req) // R12
    else $error("tx path open during flush");
  a_rd_held_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_flush |-> !rd_valid && !dma_rx_req) // R3
    else $error("rx read offered during flush");
  a_tx_flush_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && tx_flush_set |=> tx_flush ##1 !tx_byte_valid) // R12
    else $error("tx flush did not empty holding stage");
  a_dma_tx_eot: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && dma_eot && !dma_tx_en_wr |=> !dma_tx_en) // R6
    else $error("tx dma enable survived end of transfer");
  a_dma_rx_eot: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && dma_eot && !dma_rx_en_wr |=> !dma_rx_en) // R8
    else $error("rx dma enable survived end of transfer");
  a_dma_tx_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    dma_tx_req |-> dma_tx_en && !tx_flush) // R5
    else $error("tx dma request while idle");
  a_dma_rx_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    dma_rx_req |-> dma_rx_en) // R7
    else $error("rx dma request while idle");
  a_tx_en_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && dma_tx_en_wr |=> dma_tx_en == $past(dma_tx_en_wdata)) // R5
    else $error("tx dma enable write lost");
  a_rx_en_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && dma_rx_en_wr |=> dma_rx_en == $past(dma_rx_en_wdata)) // R7
    else $error("rx dma enable write lost");
  a_filter_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && filter_wr
    |=> line_filter_select == $past(line_filter_select_wdata)) // R10
    else $error("filter select write lost");
  a_scl_filter_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && line_filter_select == FLT_OFF && !filter_wr
    |=> scl_filt == $past(scl_in)) // R10
    else $error("unfiltered scl did not follow input");
  a_filter_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && line_filter_select == FLT_OFF && !filter_wr
    |=> sda_filt == $past(sda_in)) // R10
    else $error("unfiltered sda did not follow input");
  a_filter_spike: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && !filter_wr && line_filter_select == FLT_FOUR && sda_in == sda_filt
    ##1 (clk_en && !filter_wr) [*4] |-> sda_filt == $past(sda_filt, 4)) // R11
    else $error("four clock spike reached filtered sda");
endmodule // i2cfd_ctrl

//--- tb/i2cfd_dma_model.sv
// DMA controller model: drains the receive FIFO, feeds the transmit stage
`timescale 1ns/1ns
module i2cfd_dma_model
  import i2cfd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              stall,
  input  wire logic [3:0]        eot_after,
  input  wire logic              dma_rx_req,
  input  wire logic              rx_flush,
  input  wire logic              rd_valid,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic                   rd_ready,
  input  wire logic              dma_tx_req,
  input  wire logic              tx_wr_ready,
  output logic                   tx_wr_valid,
  output logic      [DATA_W-1:0] tx_wr_data,
  output logic                   dma_eot,
  output logic      [DATA_W-1:0] last_rd
);
  logic              xfer;
  logic [3:0]        moved;
  logic [DATA_W-1:0] data_ff;
  assign xfer = (rd_valid & rd_ready) | (tx_wr_valid & tx_wr_ready);
  // Idle data shows the inverse so a stale byte never passes for a new one
  assign tx_wr_data = tx_wr_valid ? data_ff : ~data_ff;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ready    <= 1'b0;
      tx_wr_valid <= 1'b0;
      dma_eot     <= 1'b0;
      moved       <= 4'h0;
      data_ff     <= 8'ha0;
      last_rd     <= 8'h00;
    end else begin
      // Never reads while a flush runs
      rd_ready <= dma_rx_req & ~stall & ~rx_flush;
      if (rd_valid & rd_ready) begin
        last_rd <= rd_data;
      end
      // Write is held until the holding stage takes it
      if (tx_wr_valid & tx_wr_ready) begin
        tx_wr_valid <= 1'b0;
        data_ff     <= data_ff + 8'h01;
      end else if (dma_tx_req & ~stall) begin
        tx_wr_valid <= 1'b1;
      end
      dma_eot <= xfer & ((moved + 4'h1) == eot_after);
      moved   <= dma_eot ? 4'h0 : moved + {3'h0, xfer};
    end
  end
endmodule // i2cfd_dma_model

//--- tb/test_i2c_flush_dma_ctrl.sv
// Self-checking bench for the flush, DMA enable and line filter block
`timescale 1ns/1ns
module test_i2c_flush_dma_ctrl;
  import i2cfd_pkg::*;
  typedef struct packed {
    logic [1:0] sel;
    logic [3:0] len;
    logic       pass;
  } i2cfd_row_t;
  i2cfd_row_t rows [7] = '{'{2'h0, 4'h1, 1'b1}, '{2'h1, 4'h1, 1'b0},
    '{2'h1, 4'h2, 1'b1}, '{2'h2, 4'h2, 1'b0}, '{2'h2, 4'h3, 1'b1},
    '{2'h3, 4'h4, 1'b0}, '{2'h3, 4'h5, 1'b1}};
  logic core_clk, sys_rst, clk_en, rx_flush_set, tx_flush_set, rx_flush;
  logic tx_flush, dma_tx_en_wr, dma_tx_en_wdata, dma_rx_en_wr, dma_eot;
  logic dma_rx_en_wdata, dma_tx_en, dma_rx_en, dma_tx_req, dma_rx_req;
  logic filter_wr, sda_in, scl_in, sda_filt, scl_filt, rx_byte_valid;
  logic rx_byte_ready, rd_valid, rd_ready, tx_wr_valid, tx_wr_ready;
  logic tx_byte_valid, tx_byte_ready, stall;
  logic [1:0]        line_filter_select_wdata, line_filter_select, lows;
  logic [3:0]        eot_after;
  logic [DATA_W-1:0] rx_byte, rd_data, tx_wr_data, tx_byte, last_rd;
  int                failures, total_checks, cycles, n;

  i2cfd_ctrl dut (.core_clk, .sys_rst, .clk_en, .rx_flush_set,
    .tx_flush_set, .rx_flush, .tx_flush, .dma_tx_en_wr, .dma_tx_en_wdata,
    .dma_rx_en_wr, .dma_rx_en_wdata, .dma_tx_en, .dma_rx_en, .dma_eot,
    .dma_tx_req, .dma_rx_req, .filter_wr, .line_filter_select_wdata,
    .line_filter_select, .sda_in, .scl_in, .sda_filt, .scl_filt,
    .rx_byte_valid, .rx_byte_ready, .rx_byte, .rd_valid, .rd_ready,
    .rd_data, .tx_wr_valid, .tx_wr_ready, .tx_wr_data, .tx_byte_valid,
    .tx_byte_ready, .tx_byte);
  i2cfd_dma_model dma (.core_clk, .sys_rst, .stall, .eot_after,
    .dma_rx_req, .rx_flush, .rd_valid, .rd_data, .rd_ready, .dma_tx_req,
    .tx_wr_ready, .tx_wr_valid, .tx_wr_data, .dma_eot, .last_rd);

  always #4 core_clk = ~core_clk;

  task automatic summarize();
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  task automatic wait_low(input logic tx);
    n = 0;
    while ((tx ? dma_tx_en : dma_rx_en) !== 1'b0 && n < 40) begin
      n++;
      step(1);
    end
  endtask

  // Freeze drops clk_en for two cycles, stretching the flush by two
  task automatic flush(input logic tx, input logic frz);
    int c;
    c = 0;
    tx_flush_set = tx;
    rx_flush_set = ~tx;
    step(1);
    tx_flush_set = 1'b0;
    rx_flush_set = 1'b0;
    while ((tx ? tx_flush : rx_flush) === 1'b1 && c < 20) begin
      c++;
      clk_en = ~frz | c < 2 | c >= 4;
      step(1);
    end
    chk(8'(c), frz ? 8'h06 : 8'h04);
  endtask

  task automatic push(input logic [DATA_W-1:0] d);
    rx_byte_valid = 1'b1;
    rx_byte = d;
    n = 0;
    while (rx_byte_ready !== 1'b1 && n < 30) begin
      n++;
      step(1);
    end
    step(1);
  endtask

  task automatic set_en(input logic tx, input logic v);
    dma_tx_en_wr = tx;
    dma_rx_en_wr = ~tx;
    dma_tx_en_wdata = v;
    dma_rx_en_wdata = v;
    step(1);
    dma_tx_en_wr = 1'b0;
    dma_rx_en_wr = 1'b0;
  endtask

  initial begin
    {core_clk, sys_rst, clk_en, sda_in, scl_in} = 5'h1f;
    {rx_flush_set, tx_flush_set, dma_tx_en_wr, dma_rx_en_wr} = 4'h0;
    {dma_tx_en_wdata, dma_rx_en_wdata, filter_wr, stall} = 4'h0;
    {rx_byte_valid, tx_byte_ready, line_filter_select_wdata} = 4'h0;
    {rx_byte, eot_after} = 12'h003;
    step(20);
    sys_rst = 1'b0;
    chk({rx_flush, tx_flush, dma_tx_en, dma_rx_en, line_filter_select,
      sda_filt, scl_filt}, 8'h03);
    chk({rd_valid, rx_byte_ready, tx_wr_ready, tx_byte_valid, dma_tx_req,
      dma_rx_req}, 8'h18);
    foreach (rows[i]) begin
      line_filter_select_wdata = rows[i].sel;
      filter_wr = 1'b1;
      step(1);
      filter_wr = 1'b0;
      step(8);
      chk(line_filter_select, rows[i].sel);
      lows = 2'h0;
      {sda_in, scl_in} = 2'h0;
      for (int k = 0; k < rows[i].len + 8; k++) begin
        if (k == rows[i].len) begin
          {sda_in, scl_in} = 2'h3;
        end
        lows |= ~{sda_filt, scl_filt};
        step(1);
      end
      chk(lows, rows[i].pass ? 2'h3 : 2'h0);
    end
    set_en(1'b1, 1'b1);
    step(4);
    chk({dma_tx_en, tx_byte_valid, dma_tx_req}, 8'h06);
    stall = 1'b1;
    for (int i = 0; i < 8; i++) begin
      push(8'(i));
    end
    chk(rx_byte_ready, 1'b0);
    rx_byte_valid = 1'b0;
    flush(1'b0, 1'b0);
    chk({rd_valid, rx_byte_ready, line_filter_select, dma_tx_en,
      tx_byte_valid}, 8'h1f);
    flush(1'b1, 1'b1);
    chk({tx_byte_valid, tx_wr_ready, dma_tx_en, dma_tx_req}, 8'h07);
    set_en(1'b1, 1'b0);
    chk({dma_tx_en, dma_tx_req}, 8'h00);
    // One transmit write is already counted toward the next end of transfer
    eot_after = 4'h4;
    push(8'h11);
    push(8'h22);
    push(8'h33);
    rx_byte_valid = 1'b0;
    set_en(1'b0, 1'b1);
    step(2);
    chk({5'h0, dma_rx_en, dma_rx_req, rd_valid}, 8'h07);
    chk(last_rd, 8'h00);
    stall = 1'b0;
    wait_low(1'b0);
    chk(last_rd, 8'h33);
    chk({dma_rx_en, dma_rx_req, rd_valid}, 8'h00);
    tx_byte_ready = 1'b1;
    eot_after = 4'h2;
    set_en(1'b1, 1'b1);
    wait_low(1'b1);
    step(1);
    chk({dma_tx_en, dma_tx_req, n < 40}, 8'h01);
    // Model writes 0xa0, 0xa1, 0xa2 in turn; the last one stays held
    chk(tx_byte, 8'ha2);
    summarize();
  end
endmodule // test_i2c_flush_dma_ctrl
